// >>> framer_timebase.sv
// Constants shared by the serial text framer and its millisecond timebase.
// Assumes one 20 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

package framer_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int UNIT_MS = 100;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_START = 6'h04;
  localparam logic [5:0] OFS_END = 6'h08;
  localparam logic [5:0] OFS_FLOW = 6'h0c;
  localparam logic [5:0] OFS_GAP = 6'h10;
  localparam logic [5:0] OFS_PTO = 6'h14;
  localparam logic [5:0] OFS_RTO = 6'h18;
  localparam logic [5:0] OFS_FLEN = 6'h1c;
  localparam logic [5:0] OFS_STAT = 6'h20;

  localparam int CF_SLEN = 0;
  localparam int CF_ELEN = 4;
  localparam int CF_BCC = 8;
  localparam int CF_SEVEN = 10;
  localparam int CF_ASCII = 11;
  localparam int CF_FLOW = 12;
  localparam int CF_BAUD = 16;
  localparam int CF_VAR = 20;
  localparam logic [31:0] CTRL_MASK = 32'h0017_7f77;

  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] START_RST = 32'h0000_0002;
  localparam logic [31:0] END_RST = 32'h0000_0003;
  localparam logic [31:0] FLOW_RST = 32'h0000_0000;
  localparam logic [14:0] GAP_RST = 15'h0000;
  localparam logic [14:0] PTO_RST = 15'h7fff;
  localparam logic [14:0] RTO_RST = 15'h7fff;
  localparam logic [9:0] FLEN_RST = 10'h200;

  localparam logic [1:0] BCC_EVEN = 2'h1;
  localparam logic [1:0] BCC_ODD = 2'h2;
  localparam logic [7:0] EVEN_MASK = 8'h00;
  localparam logic [7:0] ODD7_MASK = 8'h7f;
  localparam logic [7:0] ODD8_MASK = 8'hff;
  localparam logic [14:0] MIN_GAP_SLOW = 15'h0040;
  localparam logic [2:0] BAUD_FASTEST = 3'h6;

  localparam int FL_RXC = 0;
  localparam int FL_BCC = 1;
  localparam int FL_PTO = 2;
  localparam int FL_RTO = 3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_TEXT = 3'b010,
    TX_END = 3'b011,
    TX_BCC = 3'b100,
    TX_GAP = 3'b101
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_BODY = 2'b01,
    RX_CHECK = 2'b10
  } rx_state_type;
endpackage

////////////////////////////////////////////////////////////////////////////////

module framer_timebase #(
  parameter int CYCLES_PER_MS = framer_pkg::CYC_PER_MS,
  parameter int MS_PER_UNIT = framer_pkg::UNIT_MS
) (
  input wire logic clk,
  input wire logic srst,
  output logic ms_tick,
  output logic unit_tick
);
  import framer_pkg::*;

  typedef struct packed {
    logic [15:0] cyc;
    logic [6:0] ms;
    logic ms_tick;
    logic unit_tick;
  } tb_state_type;

  tb_state_type st, n;

  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65536 || MS_PER_UNIT < 1 || MS_PER_UNIT > 128) begin
    $error("framer_timebase: divider out of range");
  end

  always_comb begin
    n = st;
    n.ms_tick = 1'b0;
    n.unit_tick = 1'b0;
    if (st.cyc == 16'(CYCLES_PER_MS - 1)) begin
      n.cyc = 16'h0000;
      n.ms_tick = 1'b1;
      if (st.ms == 7'(MS_PER_UNIT - 1)) begin
        n.ms = 7'h00;
        n.unit_tick = 1'b1;
      end else begin
        n.ms = st.ms + 7'h01;
      end
    end else begin
      n.cyc = st.cyc + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign ms_tick = st.ms_tick;
  assign unit_tick = st.unit_tick;
endmodule

`default_nettype wire

// >>> remote_station.sv
// Remote station model on the far side of the framer's byte-wide line port.
// Assumes the framer's clock; one received byte is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none

module remote_station (
  input wire logic clk,
  input wire logic slow,
  input wire logic line_tx_valid,
  input wire logic [7:0] line_tx_byte,
  output logic line_tx_ready,
  output logic line_rx_valid,
  output logic [7:0] line_rx_byte
);
  logic [7:0] got[$];
  logic [1:0] div = 2'h0;

  initial begin
    line_tx_ready = 1'b0;
    line_rx_valid = 1'b0;
    line_rx_byte = 8'h00;
  end

  // A slow station accepts one byte in four cycles, so the framer must hold
  always @(posedge clk) begin
    div <= div + 2'h1;
    line_tx_ready <= !slow || div == 2'h3;
    if (line_tx_valid && line_tx_ready) got.push_back(line_tx_byte);
  end

  // Idle data shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    line_rx_valid <= 1'b1;
    line_rx_byte <= b;
    @(posedge clk);
    line_rx_valid <= 1'b0;
    line_rx_byte <= ~b;
  endtask
endmodule

`default_nettype wire

// >>> serial_text_framer.sv
// Serial text framer: adds and strips delimiters, block check and pacing
// around a byte stream. Assumes a byte-wide UART on the same clock on the
// line side and a register master that never needs wait states.
//
// Notes on behaviour
// [RQ1] Start delimiter: none or one to four bytes
// [RQ2] Start delimiter received restarts frame, discards earlier
// [RQ3] Transmit start delimiter right before text
// [RQ4] End delimiter: none or 1-4 bytes, default 03
// [RQ5] End delimiter received closes the current frame
// [RQ6] Transmit end delimiter right after text
// [RQ7] Delimiters are raw, never ASCII converted
// [RQ8] Check byte follows end delimiter, else text
// [RQ9] Check off, even or odd; generate and verify
// [RQ10] Even check: XOR of covered bytes
// [RQ11] Odd check: XOR inverted by 7F or FF
// [RQ12] No end delimiter: fixed length locates check
// [RQ13] ASCII mode: check over binary text, delimiter
// [RQ14] Programmable millisecond gap between transmissions
// [RQ15] Minimum gap follows line rate
// [RQ16] Flow control off or 1-2 pause/resume bytes
// [RQ17] Paused: hold transmit, ignore all but resume
// [RQ18] Pause and resume matched as raw bytes
// [RQ19] Pause timeout in 100 ms units raises error
// [RQ20] Pause and receive timeouts run independently
// [RQ21] Remote station uses the same framing settings
// [RQ22] Variable length: idle timeout completes the frame
// [RQ23] Order: start, text, end, check byte
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module serial_text_framer #(
  parameter int CYCLES_PER_MS = framer_pkg::CYC_PER_MS,
  parameter int MS_PER_UNIT = framer_pkg::UNIT_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic host_valid,
  input wire logic [7:0] host_byte,
  input wire logic host_last,
  output logic host_ready,
  output logic line_tx_valid,
  output logic [7:0] line_tx_byte,
  input wire logic line_tx_ready,
  input wire logic line_rx_valid,
  input wire logic [7:0] line_rx_byte,
  output logic rx_text_valid,
  output logic [7:0] rx_text_byte,
  output logic rx_abort,
  output logic rx_done,
  output logic tx_paused
);
  import framer_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] start_codes;
    logic [31:0] end_codes;
    logic [31:0] flow_codes;
    logic [14:0] gap_set;
    logic [14:0] pto_set;
    logic [14:0] rto_set;
    logic [9:0] flen;
    logic [3:0] flags;
    logic [31:0] rd_data;
    tx_state_type ts;
    logic [1:0] idx;
    logic hold_valid;
    logic [7:0] hold_byte;
    logic hold_last;
    logic lo_next;
    logic [7:0] tx_bcc;
    logic [14:0] gap_cnt;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic host_ready;
    logic paused;
    logic [14:0] pause_cnt;
    rx_state_type rs;
    logic [23:0] hist;
    logic [23:0] pipe;
    logic [1:0] occ;
    logic nib_hi;
    logic [3:0] nib;
    logic [7:0] rx_acc;
    logic [9:0] len_cnt;
    logic rx_busy;
    logic [14:0] rx_cnt;
    logic out_valid;
    logic [7:0] out_byte;
    logic abort;
    logic done;
  } state_type;

  state_type st, n;
  logic ms_tick, unit_tick;
  logic [2:0] slen, elen, flow_mode, baud;
  logic [1:0] bcc_mode, lag;
  logic bcc_on, ascii, var_mode;
  logic [7:0] mask, endx;
  logic [31:0] recent, rcodes;
  logic [2:0] plen, rlen;
  logic start_hit, end_hit, pause_hit, resume_hit;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic seq_match(input logic [31:0] rec, input logic [31:0] codes,
                                     input logic [2:0] len);
    logic ok;
    logic [31:0] sh;
    ok = (len != 3'h0);
    sh = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(len)) begin
        sh = codes >> (8 * (int'(len) - 1 - i));
        if (rec[8*i +: 8] != sh[7:0]) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction

  function automatic logic [7:0] xor_codes(input logic [31:0] codes, input logic [2:0] len);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(len)) begin
        x = x ^ codes[8*i +: 8];
      end
    end
    return x;
  endfunction

  function automatic logic [2:0] lim4(input logic [2:0] v);
    return (v > 3'h4) ? 3'h4 : v;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  function automatic logic [3:0] hexv(input logic [7:0] c);
    logic [7:0] t;
    t = (c <= 8'h39) ? (c - 8'h30) : ((c & 8'hdf) - 8'h37);
    return t[3:0];
  endfunction

  // A nonzero set gap below the line-rate floor is raised to the floor; zero stays zero
  function automatic logic [14:0] eff_gap(input logic [14:0] g, input logic [2:0] b);
    logic [14:0] floor_ms;
    floor_ms = MIN_GAP_SLOW >> ((b > BAUD_FASTEST) ? BAUD_FASTEST : b);
    return (g == 15'h0000) ? 15'h0000 : ((g < floor_ms) ? floor_ms : g);
  endfunction

  function automatic state_type frame_reset(input state_type s, input logic [2:0] sl);
    s.rx_acc = 8'h00;
    s.len_cnt = 10'h000;
    s.occ = 2'h0;
    s.nib_hi = 1'b0;
    s.rx_busy = 1'b0;
    s.rx_cnt = 15'h0000;
    s.rs = (sl != 3'h0) ? RX_HUNT : RX_BODY;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  framer_timebase #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .MS_PER_UNIT(MS_PER_UNIT)
  ) u_timebase (
    .clk(clk),
    .srst(srst),
    .ms_tick(ms_tick),
    .unit_tick(unit_tick)
  );

  assign slen = st.ctrl[CF_SLEN +: 3];
  assign elen = st.ctrl[CF_ELEN +: 3];
  assign bcc_mode = st.ctrl[CF_BCC +: 2];
  assign flow_mode = st.ctrl[CF_FLOW +: 3];
  assign baud = st.ctrl[CF_BAUD +: 3];
  assign ascii = st.ctrl[CF_ASCII];
  assign var_mode = st.ctrl[CF_VAR];
  assign bcc_on = (bcc_mode == BCC_EVEN) || (bcc_mode == BCC_ODD); // RQ9
  assign mask = (bcc_mode != BCC_ODD) ? EVEN_MASK
              : (st.ctrl[CF_SEVEN] ? ODD7_MASK : ODD8_MASK); // RQ10 RQ11
  assign endx = xor_codes(st.end_codes, elen); // RQ13
  assign lag = (elen == 3'h0) ? 2'h0 : 2'(elen - 3'h1);
  assign recent = {st.hist, line_rx_byte};
  // Flow table: pause bytes first, resume bytes after them
  assign plen = (flow_mode >= 3'h3) ? 3'h2 : 3'h1; // RQ16
  assign rlen = (flow_mode == 3'h2 || flow_mode == 3'h4) ? 3'h2 : 3'h1;
  assign rcodes = (plen == 3'h2) ? (st.flow_codes >> 16) : (st.flow_codes >> 8);
  assign start_hit = seq_match(recent, st.start_codes, slen); // RQ2 RQ7
  assign end_hit = seq_match(recent, st.end_codes, elen); // RQ5 RQ7
  assign pause_hit = (flow_mode != 3'h0) && seq_match(recent, st.flow_codes, plen); // RQ18
  assign resume_hit = (flow_mode != 3'h0) && seq_match(recent, rcodes, rlen); // RQ18

  always_comb begin
    logic can;
    logic emit;
    logic [7:0] e;
    logic [7:0] b;
    logic [3:0] set;
    logic [3:0] clr;
    can = (!st.tx_valid || line_tx_ready) && !st.paused;
    emit = 1'b0;
    e = 8'h00;
    b = 8'h00;
    set = 4'h0;
    clr = 4'h0;
    n = st;
    n.rd_data = 32'h0000_0000;
    n.abort = 1'b0;
    n.done = 1'b0;
    n.out_valid = 1'b0;

    // Register port; delimiter lengths above four are stored as four
    if (wr_en) begin
      case (addr)
        OFS_CTRL: begin
          n.ctrl = wr_data & CTRL_MASK;
          n.ctrl[CF_SLEN +: 3] = lim4(wr_data[CF_SLEN +: 3]); // RQ1
          n.ctrl[CF_ELEN +: 3] = lim4(wr_data[CF_ELEN +: 3]); // RQ4
          n.ctrl[CF_FLOW +: 3] = lim4(wr_data[CF_FLOW +: 3]); // RQ16
        end
        OFS_START: n.start_codes = wr_data;
        OFS_END: n.end_codes = wr_data;
        OFS_FLOW: n.flow_codes = wr_data;
        OFS_GAP: n.gap_set = wr_data[14:0];
        OFS_PTO: n.pto_set = wr_data[14:0];
        OFS_RTO: n.rto_set = wr_data[14:0];
        OFS_FLEN: n.flen = wr_data[9:0];
        OFS_STAT: clr = wr_data[3:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        OFS_CTRL: n.rd_data = st.ctrl;
        OFS_START: n.rd_data = st.start_codes;
        OFS_END: n.rd_data = st.end_codes;
        OFS_FLOW: n.rd_data = st.flow_codes;
        OFS_GAP: n.rd_data = {17'h00000, st.gap_set};
        OFS_PTO: n.rd_data = {17'h00000, st.pto_set};
        OFS_RTO: n.rd_data = {17'h00000, st.rto_set};
        OFS_FLEN: n.rd_data = {22'h000000, st.flen};
        OFS_STAT: n.rd_data = {26'h0000000, st.ts != TX_IDLE, st.paused, st.flags};
        default: n.rd_data = 32'h0000_0000;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit side
    if (st.tx_valid && line_tx_ready) begin
      n.tx_valid = 1'b0;
    end
    if (host_valid && st.host_ready) begin
      n.hold_valid = 1'b1;
      n.hold_byte = host_byte;
      n.hold_last = host_last;
    end
    case (st.ts)
      TX_IDLE: begin
        n.idx = 2'h0;
        n.tx_bcc = 8'h00;
        n.lo_next = 1'b0;
        if (st.hold_valid) begin
          n.ts = (slen != 3'h0) ? TX_START : TX_TEXT; // RQ3 RQ23
        end
      end
      TX_START: if (can) begin
        emit = 1'b1;
        e = st.start_codes[8*st.idx +: 8]; // RQ7
        n.idx = st.idx + 2'h1;
        if ({1'b0, st.idx} == slen - 3'h1) begin
          n.ts = TX_TEXT; // RQ3
          n.idx = 2'h0;
        end
      end
      TX_TEXT: if (can && st.hold_valid) begin
        emit = 1'b1;
        if (ascii && !st.lo_next) begin
          e = hexc(st.hold_byte[7:4]);
          n.lo_next = 1'b1;
        end else begin
          e = ascii ? hexc(st.hold_byte[3:0]) : st.hold_byte;
          n.tx_bcc = st.tx_bcc ^ st.hold_byte; // RQ13
          n.hold_valid = 1'b0;
          n.lo_next = 1'b0;
          if (st.hold_last) begin
            if (elen != 3'h0) begin
              n.ts = TX_END; // RQ6 RQ23
            end else if (bcc_on) begin
              n.ts = TX_BCC; // RQ8
            end else begin
              n.ts = TX_GAP;
              n.gap_cnt = eff_gap(st.gap_set, baud);
            end
          end
        end
      end
      TX_END: if (can) begin
        emit = 1'b1;
        e = st.end_codes[8*st.idx +: 8]; // RQ7
        n.tx_bcc = st.tx_bcc ^ e;
        n.idx = st.idx + 2'h1;
        if ({1'b0, st.idx} == elen - 3'h1) begin
          n.idx = 2'h0;
          n.ts = bcc_on ? TX_BCC : TX_GAP; // RQ8 RQ23
          n.gap_cnt = eff_gap(st.gap_set, baud); // RQ15
        end
      end
      TX_BCC: if (can) begin
        emit = 1'b1;
        e = st.tx_bcc ^ mask; // RQ10 RQ11
        n.ts = TX_GAP;
        n.gap_cnt = eff_gap(st.gap_set, baud); // RQ15
      end
      TX_GAP: begin
        if (st.gap_cnt == 15'h0000) begin
          n.ts = TX_IDLE;
        end else if (ms_tick) begin
          n.gap_cnt = st.gap_cnt - 15'h0001; // RQ14
        end
      end
      default: n.ts = TX_IDLE;
    endcase
    if (emit) begin
      n.tx_valid = 1'b1;
      n.tx_byte = e;
    end
    n.host_ready = !n.hold_valid;

    // Pause watchdog counts unit ticks of the free-running timebase from the pause byte onward
    if (st.paused && st.pto_set != 15'h0000 && unit_tick && st.pause_cnt != st.pto_set) begin
      n.pause_cnt = st.pause_cnt + 15'h0001;
      if (st.pause_cnt + 15'h0001 == st.pto_set) begin
        set[FL_PTO] = 1'b1; // RQ19
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive side; its timer ignores the pause state entirely
    if (st.rx_busy && st.rto_set != 15'h0000 && unit_tick) begin
      n.rx_cnt = st.rx_cnt + 15'h0001; // RQ20
      if (n.rx_cnt >= st.rto_set) begin
        if (var_mode) begin
          n.done = 1'b1; // RQ22
        end else begin
          set[FL_RTO] = 1'b1;
          n.abort = 1'b1;
        end
        n = frame_reset(n, slen);
      end
    end
    if (line_rx_valid) begin
      n.hist = recent[23:0];
      if (flow_mode != 3'h0 && st.paused) begin
        if (resume_hit) begin
          n.paused = 1'b0; // RQ17
        end
      end else if (pause_hit) begin
        n.paused = 1'b1; // RQ17
        n.pause_cnt = 15'h0000;
      end else if (start_hit) begin
        n = frame_reset(n, slen); // RQ2
        n.rs = RX_BODY;
        n.abort = 1'b1;
        n.rx_busy = 1'b1;
      end else begin
        case ((st.rs == RX_HUNT && slen == 3'h0) ? RX_BODY : st.rs)
          RX_HUNT: ;
          RX_BODY: begin
            n.rx_busy = 1'b1;
            if (var_mode) begin
              n.rx_cnt = 15'h0000;
            end
            if (end_hit) begin
              // Held-back bytes are all end delimiter and are dropped
              n.occ = 2'h0;
              if (bcc_on) begin
                n.rs = RX_CHECK; // RQ5 RQ8
              end else begin
                n.done = 1'b1; // RQ5
                n = frame_reset(n, slen);
              end
            end else begin
              n.pipe = {st.pipe[15:0], line_rx_byte};
              if (st.occ == lag) begin
                b = (lag == 2'h0) ? line_rx_byte : st.pipe[8*(lag - 2'h1) +: 8];
                if (ascii && !st.nib_hi) begin
                  n.nib = hexv(b);
                  n.nib_hi = 1'b1;
                end else begin
                  b = ascii ? {st.nib, hexv(b)} : b;
                  n.nib_hi = 1'b0;
                  n.out_valid = 1'b1;
                  n.out_byte = b;
                  n.rx_acc = st.rx_acc ^ b; // RQ13
                  n.len_cnt = st.len_cnt + 10'h001;
                  if (elen == 3'h0 && !var_mode && n.len_cnt == st.flen) begin
                    if (bcc_on) begin
                      n.rs = RX_CHECK; // RQ12
                    end else begin
                      n.done = 1'b1;
                      n = frame_reset(n, slen);
                    end
                  end
                end
              end else begin
                n.occ = st.occ + 2'h1;
              end
            end
          end
          RX_CHECK: begin
            if (line_rx_byte != (st.rx_acc ^ endx ^ mask)) begin
              set[FL_BCC] = 1'b1; // RQ9
            end
            n.done = 1'b1;
            n = frame_reset(n, slen);
          end
          default: n = frame_reset(n, slen);
        endcase
      end
    end
    if (n.done) begin
      set[FL_RXC] = 1'b1;
    end
    n.flags = (st.flags & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.ctrl <= CTRL_RST;
      st.start_codes <= START_RST;
      st.end_codes <= END_RST;
      st.flow_codes <= FLOW_RST;
      st.gap_set <= GAP_RST;
      st.pto_set <= PTO_RST;
      st.rto_set <= RTO_RST;
      st.flen <= FLEN_RST;
    end else begin
      st <= n;
    end
  end

  assign rd_data = st.rd_data;
  assign host_ready = st.host_ready;
  assign line_tx_valid = st.tx_valid;
  assign line_tx_byte = st.tx_byte;
  assign rx_text_valid = st.out_valid;
  assign rx_text_byte = st.out_byte;
  assign rx_abort = st.abort;
  assign rx_done = st.done;
  assign tx_paused = st.paused;

  ////////////////////////////////////////////////////////////////////////////

  tx_pause_hold_a: assert property ( // RQ17
    @(posedge clk) disable iff (srst)
    (st.paused && (!st.tx_valid || line_tx_ready)) |=> !st.tx_valid)
    else $error("byte sent while paused");

  tx_start_first_a: assert property ( // RQ3
    @(posedge clk) disable iff (srst)
    (st.ts == TX_IDLE && slen != 3'h0) |=> (st.ts == TX_IDLE || st.ts == TX_START))
    else $error("frame began without start delimiter");

  tx_end_follow_a: assert property ( // RQ6
    @(posedge clk) disable iff (srst)
    (st.ts == TX_TEXT && elen != 3'h0) |=> (st.ts == TX_TEXT || st.ts == TX_END))
    else $error("text not followed by end delimiter");

  tx_check_value_a: assert property ( // RQ10
    @(posedge clk) disable iff (srst)
    (st.ts == TX_BCC && !st.paused && (!st.tx_valid || line_tx_ready))
    |=> st.tx_valid && st.tx_byte == ($past(st.tx_bcc) ^ $past(mask)) && st.ts == TX_GAP)
    else $error("wrong check byte sent");

  tx_gap_hold_a: assert property ( // RQ14
    @(posedge clk) disable iff (srst)
    (st.ts == TX_GAP && st.gap_cnt != 15'h0000) |=> st.ts == TX_GAP)
    else $error("send gap cut short");

  rx_start_abort_a: assert property ( // RQ2
    @(posedge clk) disable iff (srst)
    (line_rx_valid && start_hit && !st.paused && !pause_hit) |=> rx_abort && st.rs == RX_BODY
    && st.len_cnt == 10'h000)
    else $error("start delimiter did not restart frame");

  rx_end_close_a: assert property ( // RQ5
    @(posedge clk) disable iff (srst)
    (line_rx_valid && st.rs == RX_BODY && end_hit && !start_hit && !st.paused && !pause_hit)
    |=> (bcc_on ? st.rs == RX_CHECK : rx_done) && !rx_text_valid)
    else $error("end delimiter did not close frame");

  rx_check_flag_a: assert property ( // RQ9
    @(posedge clk) disable iff (srst)
    (line_rx_valid && st.rs == RX_CHECK && !st.paused && !pause_hit && !start_hit
    && line_rx_byte != (st.rx_acc ^ endx ^ mask)) |=> st.flags[FL_BCC] && rx_done)
    else $error("bad check byte not flagged");

  pause_timeout_a: assert property ( // RQ19
    @(posedge clk) disable iff (srst)
    (st.paused && unit_tick && st.pto_set != 15'h0000 && st.pause_cnt + 15'h0001 == st.pto_set)
    |=> st.flags[FL_PTO])
    else $error("pause timeout not raised");
endmodule

`default_nettype wire

// >>> test_serial_text_framer.sv
// Self-checking bench: transmit and receive framing, check byte and pausing.
// Assumes the remote station model as the line partner.
`timescale 1ns/10ps
`default_nettype none

module test_serial_text_framer;
  import framer_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic host_valid = 1'b0;
  logic [7:0] host_byte = 8'h00;
  logic host_last = 1'b0;
  logic [31:0] rd_data;
  logic [7:0] line_tx_byte, line_rx_byte, rx_text_byte;
  logic host_ready, line_tx_valid, line_tx_ready, line_rx_valid;
  logic rx_text_valid, rx_abort, rx_done, tx_paused;
  logic [7:0] rxq[$];
  int n_done = 0;
  int n_abort = 0;
  int n_fail = 0;
  int compares = 0;

  serial_text_framer #(.CYCLES_PER_MS(20), .MS_PER_UNIT(2)) i_dut (
    .clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .host_valid,
    .host_byte, .host_last, .host_ready, .line_tx_valid, .line_tx_byte,
    .line_tx_ready, .line_rx_valid, .line_rx_byte, .rx_text_valid,
    .rx_text_byte, .rx_abort, .rx_done, .tx_paused);
  remote_station u_far (.clk, .slow, .line_tx_valid, .line_tx_byte,
    .line_tx_ready, .line_rx_valid, .line_rx_byte);

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (rx_text_valid === 1'b1) rxq.push_back(rx_text_byte);
    if (rx_done === 1'b1) n_done++;
    if (rx_abort === 1'b1) n_abort++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    report_and_stop();
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic host_send(input logic [7:0] b, input logic last);
    int n;
    @(posedge clk);
    host_valid <= 1'b1;
    host_byte <= b;
    host_last <= last;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_ready !== 1'b1 && n < 100);
    host_valid <= 1'b0;
    if (host_ready !== 1'b1) hang();
  endtask

  task automatic expect_line(input logic [7:0] exp[]);
    int n;
    for (n = 0; n < 2000 && u_far.got.size() < exp.size(); n++) @(posedge clk);
    if (u_far.got.size() < exp.size()) hang();
    foreach (exp[i]) check("line byte", u_far.got[i], exp[i]);
    u_far.got.delete();
  endtask

  task automatic send_line(input logic [7:0] f[]);
    foreach (f[i]) u_far.send(f[i]);
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    logic [31:0] d;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_END, d);
    check("end reset", d, END_RST);
    rd(6'h3c, d);
    check("unmapped", d, 32'h0);
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0111);
    host_send(8'h31, 1'b0);
    host_send(8'h32, 1'b1);
    expect_line('{8'h02, 8'h31, 8'h32, 8'h03, 8'h31 ^ 8'h32 ^ 8'h03});
    wr(OFS_CTRL, 32'h0000_0211);
    host_send(8'h41, 1'b1);
    expect_line('{8'h02, 8'h41, 8'h03, 8'h42 ^ ODD8_MASK});
    wr(OFS_CTRL, 32'h0000_0611);
    host_send(8'h41, 1'b1);
    expect_line('{8'h02, 8'h41, 8'h03, 8'h42 ^ ODD7_MASK});
    wr(OFS_CTRL, 32'h0000_0101);
    host_send(8'h41, 1'b1);
    expect_line('{8'h02, 8'h41, 8'h41});
    wr(OFS_CTRL, 32'h0000_0911);
    host_send(8'h4a, 1'b1);
    expect_line('{8'h02, 8'h34, 8'h41, 8'h03, 8'h4a ^ 8'h03});
    slow <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0111);
    send_line('{8'h02, 8'h41, 8'h03, 8'h00});
    rd(OFS_STAT, d);
    check("check error", d[1], 1'b1);
    wr(OFS_STAT, 32'h0000_000f);
    send_line('{8'h02, 8'h41, 8'h03, 8'h42});
    check("rx text", rxq[$], 8'h41);
    check("rx done", n_done, 2);
    rd(OFS_STAT, d);
    check("check ok", d[1], 1'b0);
    d = n_abort;
    send_line('{8'h02, 8'h55, 8'h02, 8'h66, 8'h03, 8'h65});
    check("restart", n_abort > d, 1'b1);
    check("rx text", rxq[$], 8'h66);
    wr(OFS_START, 32'h0000_2a02);
    wr(OFS_FLEN, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0102);
    d = n_done;
    send_line('{8'h02, 8'h2a, 8'h41, 8'h42, 8'h03});
    check("fixed end", n_done, d + 32'h1);
    check("fixed text", rxq[$], 8'h42);
    rd(OFS_STAT, d);
    check("fixed check", d[1], 1'b0);
    wr(OFS_RTO, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0010_0011);
    d = n_done;
    send_line('{8'h02, 8'h58});
    repeat (100) @(posedge clk);
    check("idle close", n_done, d + 32'h1);
    check("idle text", rxq[$], 8'h58);
    wr(OFS_FLOW, 32'h0000_1113);
    wr(OFS_PTO, 32'h0000_0001);
    wr(OFS_GAP, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_1111);
    send_line('{8'h13});
    check("paused", tx_paused, 1'b1);
    host_send(8'h41, 1'b1);
    d = n_abort;
    send_line('{8'h41, 8'h02});
    repeat (200) @(posedge clk);
    check("held", u_far.got.size(), 0);
    check("ignored", tx_paused, 1'b1);
    check("no restart", n_abort, d);
    rd(OFS_STAT, d);
    check("pause timeout", d[2], 1'b1);
    send_line('{8'h11});
    expect_line('{8'h02, 8'h41, 8'h03, 8'h42});
    repeat (1200) @(posedge clk);
    rd(OFS_STAT, d);
    check("gap busy", d[5], 1'b1);
    repeat (100) @(posedge clk);
    rd(OFS_STAT, d);
    check("gap over", d[5], 1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
